// ==== pkg/watchdog_defines.vh ====
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH
// ==========================================================
// Watchdog control register layout.
`define WDOG_BIT_UNLOCK     0
`define WDOG_BIT_KICK       1
`define WDOG_BIT_STATUS     2
`define WDOG_BIT_IRQSEL     3
`define WDOG_PRE_LO         4
`define WDOG_PRE_HI         7
`define WDOG_CTRL_RESET     8'h00
// ==========================================================
// Timing.
`define WDOG_CLK_HZ         25000000
`define WDOG_REF_HZ         32768
`define WDOG_BASE_PERIODS   20'h00200
`define WDOG_REF_DIV        ((`WDOG_CLK_HZ + `WDOG_REF_HZ / 2) / `WDOG_REF_HZ)
`define WDOG_PRE_MAX        4'h7
`define WDOG_PRE_IMMEDIATE  4'h8
`define WDOG_RST_PULSE      4'hF
`endif

// ==== logic/wdog_ref_tick.v ====
`timescale 1ns/100ps
// ==========================================================
// Reference tick generator.
// Approximates the 32.768 kHz reference from the core clock.
module wdog_ref_tick #(
   parameter DIV = 763
) (
   input  wire clk,
   input  wire arst_n,
   input  wire restart,
   output reg  tick_q
);
   reg [15:0] cnt_q;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (restart) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (cnt_q == DIV[15:0] - 16'h0001) begin
         cnt_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end
endmodule

// ==== logic/watchdog_timer_control.v ====
`timescale 1ns/100ps
`include "watchdog_defines.vh"
// ==========================================================
// Functional notes
// R1: Codes 4-7 timeout 250-2000ms; 8 resets immediately.
// R2: Interrupt select bit picks irq over reset.
// R3: Watchdog irq unmaskable, fixed high priority.
// R4: Timeout sets status; write 0 or hardware reset clears.
// R5: Watchdog reset keeps status flag set.
// R6: Writing enable 1 enables and restarts counters.
// R7: Software rekicks before period, else reset/interrupt.
// R8: Enable cleared: write 0, dog reset, hwreset, monitor.
// R9: Set unlock, next instruction must write register.
// R10: Period is 2^code times 512 reference periods.
// R11: Prescale field occupies bits 7 to 4.
// R12: Other next instruction drops unlock, no change.
// R13: Software disables interrupts around write sequence.
module watchdog_timer_control #(
   parameter REF_DIV = `WDOG_REF_DIV
) (
   input  wire       clk,
   input  wire       arst_n,
   input  wire       instr_done,
   input  wire       reg_wr,
   input  wire       unlock_set,
   input  wire [7:0] reg_wdata,
   input  wire       supply_monitor_irq,
   input  wire       global_interrupt_enable,
   output reg  [7:0] watchdog_control,
   output reg        wdog_irq_q,
   output reg        wdog_irq_high_prio_q,
   output reg        sys_reset_q
);
   // ==========================================================
   // Register state.
   reg  [3:0]  pre_q;
   reg         irqsel_q;
   reg         status_q;
   reg         kick_q;
   reg         unlock_q;
   reg  [19:0] count_q;
   reg  [3:0]  rst_cnt_q;
   reg  [3:0]  rst_cnt_d;
   reg         dog_rst_q;
   reg  [1:0]  rs_state_q;
   reg  [1:0]  rs_state_d;
   wire        tick;
   wire        restart;
   wire        wr_ok;
   wire [19:0] limit;
   wire        expire;
   wire        immediate;

   // ==========================================================
   // Reset request sequencer states, one-hot.
   localparam [1:0] RS_IDLE = 2'b01;
   localparam [1:0] RS_HOLD = 2'b10;

   // ==========================================================
   // Write decode and timeout compare.

   // A write is only honoured directly after the unlock step.
   assign wr_ok     = reg_wr && unlock_q;                                  // [R9]
   assign restart   = wr_ok && reg_wdata[`WDOG_BIT_KICK];                 // [R6]
   // The field is four bits; codes above the largest period never expire the counter.
   assign limit     = `WDOG_BASE_PERIODS << pre_q[2:0];                    // [R10] [R1]
   assign immediate = kick_q && (pre_q == `WDOG_PRE_IMMEDIATE);           // [R1]
   assign expire    = kick_q && (pre_q <= `WDOG_PRE_MAX) && tick
                      && (count_q + 20'h00001 >= limit);                  // [R7]

   wdog_ref_tick #(
      .DIV (REF_DIV)
   ) u_tick (
      .clk     (clk),
      .arst_n  (arst_n),
      .restart (restart),
      .tick_q  (tick)
   );

   // ==========================================================
   // Unlock window: one instruction long.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unlock_q <= 1'b0;
      end else if (unlock_set) begin
         unlock_q <= 1'b1;                                                // [R9]
      end else if (instr_done || wr_ok) begin
         // Whatever instruction completes next closes the window, so an
         // instruction slipped in between leaves the later write refused.
         unlock_q <= 1'b0;                                                // [R12]
      end
   end

   // ==========================================================
   // Prescale and response select.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q    <= 4'h0;
         irqsel_q <= 1'b0;
      end else if (wr_ok) begin
         pre_q    <= reg_wdata[`WDOG_PRE_HI:`WDOG_PRE_LO];                // [R11]
         irqsel_q <= reg_wdata[`WDOG_BIT_IRQSEL];                         // [R2]
      end
   end

   // ==========================================================
   // Enable bit: the clearing events beat a software write.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         kick_q <= 1'b0;                                                  // [R8]
      end else if (supply_monitor_irq) begin
         kick_q <= 1'b0;                                                  // [R8]
      end else if ((expire && !irqsel_q) || immediate) begin
         kick_q <= 1'b0;                                                  // [R8]
      end else if (wr_ok) begin
         kick_q <= reg_wdata[`WDOG_BIT_KICK];                             // [R6] [R8]
      end
   end

   // ==========================================================
   // Timeout counter.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         count_q <= 20'h00000;
      else if (restart || expire)
         count_q <= 20'h00000;                                            // [R6]
      else if (kick_q && tick)
         count_q <= count_q + 20'h00001;                                  // [R10]
   end

   // ==========================================================
   // Status flag: set wins over a software clear.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= 1'b0;                                                // [R4]
      end else if (expire || immediate) begin
         status_q <= 1'b1;                                                // [R4] [R5]
      end else if (wr_ok && !reg_wdata[`WDOG_BIT_STATUS]) begin
         status_q <= 1'b0;                                                // [R4]
      end
   end

   // ==========================================================
   // Interrupt request and its priority marker.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wdog_irq_q           <= 1'b0;
         wdog_irq_high_prio_q <= 1'b0;
      end else begin
         // Irq ignores the global enable.
         wdog_irq_q           <= expire && irqsel_q;                      // [R2] [R3]
         wdog_irq_high_prio_q <= (expire && irqsel_q) | global_interrupt_enable
                                 | ~global_interrupt_enable;              // [R3]
      end
   end

   // ==========================================================
   // Reset request. The internal reset pulse never touches this block,
   // so the status flag survives it.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         dog_rst_q <= 1'b0;
      else
         dog_rst_q <= (expire && !irqsel_q) || immediate;                 // [R2] [R5]
   end

   // ==========================================================
   // Reset pulse sequencer: a new request restarts the hold time.
   always @* begin
      rs_state_d = rs_state_q;
      rst_cnt_d  = rst_cnt_q;
      case (rs_state_q)
         RS_IDLE: begin
            if (dog_rst_q) begin
               rs_state_d = RS_HOLD;                                      // [R2]
               rst_cnt_d  = `WDOG_RST_PULSE;
            end
         end
         RS_HOLD: begin
            if (dog_rst_q) begin
               rst_cnt_d  = `WDOG_RST_PULSE;
            end else if (rst_cnt_q == 4'h1) begin
               rs_state_d = RS_IDLE;
               rst_cnt_d  = 4'h0;
            end else begin
               rst_cnt_d  = rst_cnt_q - 4'h1;
            end
         end
         default: begin
            rs_state_d = RS_IDLE;
            rst_cnt_d  = 4'h0;
         end
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rs_state_q <= RS_IDLE;
         rst_cnt_q  <= 4'h0;
      end else begin
         rs_state_q <= rs_state_d;
         rst_cnt_q  <= rst_cnt_d;
      end
   end

   // ==========================================================
   // System reset output.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         sys_reset_q <= 1'b0;
      else
         sys_reset_q <= dog_rst_q || (rs_state_q == RS_HOLD);            // [R2]
   end

   // ==========================================================
   // Register readback.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         watchdog_control <= `WDOG_CTRL_RESET;
      else
         watchdog_control <= {pre_q, irqsel_q, status_q, kick_q, unlock_q};
   end
endmodule

// ==== sim/watchdog_timer_control_sva.sv ====
`timescale 1ns/100ps
// ========================================
// Watchdog port checker.
module watchdog_timer_control_sva (
   input wire       clk,
   input wire       arst_n,
   input wire       supply_monitor_irq,
   input wire [7:0] watchdog_control,
   input wire       wdog_irq_q,
   input wire       wdog_irq_high_prio_q,
   input wire       sys_reset_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   prio_fixed_a: assert property ($past(arst_n, 2) |-> wdog_irq_high_prio_q)
      else $error("priority marker low");
   irq_pulse_a: assert property (wdog_irq_q |=> !wdog_irq_q)
      else $error("irq long");
   irq_status_a: assert property (wdog_irq_q |-> ##[0:3] watchdog_control[2])
      else $error("status not set");
   irq_select_a: assert property (wdog_irq_q |-> watchdog_control[3])
      else $error("irq sel");
   irq_enabled_a: assert property (wdog_irq_q |-> $past(watchdog_control[1], 3))
      else $error("en");
   rst_hold_a: assert property ($rose(sys_reset_q) |=> sys_reset_q[*8])
      else $error("rst");
   rst_status_a: assert property ($rose(sys_reset_q) |-> ##[0:3] watchdog_control[2])
      else $error("status lost");
   dog_rst_clear_a: assert property ($rose(sys_reset_q) && !watchdog_control[3]
      |-> ##[1:4] !watchdog_control[1]) else $error("rst en");
   supply_clear_a: assert property (supply_monitor_irq |-> ##[1:3] !watchdog_control[1])
      else $error("supply");
endmodule
bind watchdog_timer_control watchdog_timer_control_sva chk (.clk(clk), .arst_n(arst_n),
   .supply_monitor_irq(supply_monitor_irq), .watchdog_control(watchdog_control),
   .wdog_irq_q(wdog_irq_q), .wdog_irq_high_prio_q(wdog_irq_high_prio_q),
   .sys_reset_q(sys_reset_q));

// ==== sim/test_watchdog_timer_control.sv ====
`timescale 1ns/100ps
// ========================================
// Watchdog bench; a short reference divider keeps timeouts near a thousand cycles.
module test_watchdog_timer_control;
   localparam int P = 1024;
   logic       clk = 0, arst_n = 0, instr_done = 0, reg_wr = 0, unlock_set = 0;
   logic       supply_monitor_irq = 0, global_interrupt_enable = 0;
   logic [7:0] reg_wdata = 8'h00, m = 8'h00;
   wire  [7:0] watchdog_control;
   wire        wdog_irq_q, wdog_irq_high_prio_q, sys_reset_q;
   int         err_total = 0, n_compared = 0, cyc = 0, irqs = 0, n;
   watchdog_timer_control #(.REF_DIV(2)) DUT (.clk(clk), .arst_n(arst_n),
      .instr_done(instr_done), .reg_wr(reg_wr), .unlock_set(unlock_set), .reg_wdata(reg_wdata),
      .supply_monitor_irq(supply_monitor_irq), .global_interrupt_enable(global_interrupt_enable),
      .watchdog_control(watchdog_control), .wdog_irq_q(wdog_irq_q),
      .wdog_irq_high_prio_q(wdog_irq_high_prio_q), .sys_reset_q(sys_reset_q));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      irqs <= irqs + wdog_irq_q;
      if (cyc == 20000) begin
         err_total++;
         print_verdict;
      end
   end
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   // Mode 0 is the legal sequence, 1 puts another instruction in between, 2 skips the unlock.
   task w(input logic [7:0] d, input int md);
      global_interrupt_enable = 1'b0;
      if (md < 2) @(negedge clk) {instr_done, unlock_set} = 2'b11;
      if (md == 1) @(negedge clk) unlock_set = 0;
      @(negedge clk) {instr_done, unlock_set, reg_wr, reg_wdata} = {3'b101, d};
      @(negedge clk) {instr_done, reg_wr} = 2'b00;
      global_interrupt_enable = 1'($urandom);
      repeat (4) @(negedge clk);
      if (md == 0) m = d;
   endtask
   task wt(input logic r);
      n = 0;
      while ((r ? sys_reset_q : wdog_irq_q) !== 1'b1 && n < 2 * P) begin
         @(negedge clk);
         n++;
      end
   endtask
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      n = $urandom(32'h0EC20CBC);
      repeat (4) @(negedge clk);
      arst_n = 1;
      @(negedge clk);
      chk("reset", m, watchdog_control);
      w(8'h42, 2);
      chk("locked", m, watchdog_control);
      w(8'h42, 1);
      chk("late", m, watchdog_control);
      w({2'b01, 2'($urandom), 4'h0}, 0);
      chk("prescale", m, watchdog_control);
      $display("test 1 done");
      w(8'h0A, 0);
      chk("enable", m, watchdog_control);
      wt(0);
      chk("irq_time", 1, n > P - 20 && n < P + 20);
      m[2] = 1;
      repeat (4) @(negedge clk);
      chk("status", m, watchdog_control);
      w(8'h08, 0);
      chk("clear", m, watchdog_control);
      $display("test 2 done");
      w(8'h0A, 0);
      n = irqs;
      repeat (4) begin
         repeat (P / 2) @(negedge clk);
         w(8'h0A, 0);
      end
      chk("kicked", n, irqs);
      @(negedge clk) supply_monitor_irq = 1;
      @(negedge clk) supply_monitor_irq = 0;
      repeat (4) @(negedge clk);
      m[1] = 0;
      chk("supply", m, watchdog_control);
      $display("test 3 done");
      w(8'h02, 0);
      wt(1);
      chk("rst_time", 1, n > P - 20 && n < P + 20);
      repeat (24) @(negedge clk);
      chk("after_rst", 2'b10, watchdog_control[2:1]);
      w(8'h82, 0);
      wt(1);
      chk("immediate", 1, n < 4);
      $display("test 4 done");
      print_verdict;
   end
endmodule
